// ===== core/eegrd_pkg.sv
/*
 * Shared constants of the two-wire EEPROM guard: addressing, filter,
 * write-cycle and bus-timing counts, host command codes.
 * Assumes a 25 MHz system clock and a 30 ns link sampling clock.
 */
package eegrd_pkg;
   // Clock periods in ns.
   localparam int SYS_NS  = 40;
   localparam int LINK_NS = 30;

   // Value is arbitrary; both ends must agree on it.
   localparam logic [3:0] DEV_CODE    = 4'h6;
   localparam logic       SLAVE_SEL_A = 1'h0;
   localparam logic       SLAVE_SEL_B = 1'h0;

   // Pulses up to this width are filtered out.
   localparam int         FILT_NS  = 100;
   localparam logic [2:0] FILT_CYC = 3'(FILT_NS / LINK_NS + 2);

   // Internal write cycle, power-on hold and bus clock period.
   localparam int         WR_NS   = 5000000;
   localparam int         POR_NS  = 1000;
   localparam logic [7:0] POR_CYC = 8'(POR_NS / SYS_NS);
   localparam int         SCL_NS  = 10000;
   localparam logic [7:0] QTR_CYC = 8'(SCL_NS / (4 * SYS_NS));

   localparam logic [3:0] BIT_LAST  = 4'h8;
   localparam int         MEM_DEPTH = 512;

   // Host commands.
   localparam logic [1:0] CMD_WRITE = 2'h0;
   localparam logic [1:0] CMD_READ  = 2'h1;
   localparam logic [1:0] CMD_SRST  = 2'h2;
endpackage

// ===== core/eegrd_if.sv
/*
 * Two-wire bus between host and EEPROM guard.
 * Assumes the pull-up is modelled here; the ends never drive Z.
 */
`timescale 1ns/10ps
interface eegrd_if;
   logic scl;
   logic sda_m_out;
   logic sda_m_oe;
   logic sda_d_out;
   logic sda_d_oe;
   logic wp;
   logic sda;

   // The pull-up in this assign holds the line high when nobody pulls it low.
   assign sda = (sda_m_oe ? sda_m_out : 1'b1)
              & (sda_d_oe ? sda_d_out : 1'b1);

   modport dev  (input scl, sda, wp, output sda_d_out, sda_d_oe);
   modport host (output scl, sda_m_out, sda_m_oe, wp, input sda);
endinterface

// ===== core/eegrd_dev.sv
/*
 * EEPROM slave end: glitch filter, address decode, software reset,
 * write guard, page buffer and internal write cycle.
 * Assumes the link clock samples the bus; the write cycle runs on
 * the system clock.
 */
`timescale 1ns/10ps
module eegrd_dev
   import eegrd_pkg::*;
#(
   parameter int WR_CYC = WR_NS / SYS_NS
) (
   // Clocks and reset
   input  wire logic clk_sys_in,
   input  wire logic link_clk_in,
   input  wire logic nrst_in,
   // Two-wire bus
   eegrd_if.dev      bus,
   // Supply monitor and status
   input  wire logic supply_low_in,
   output logic      busy_out
);

   typedef enum logic [4:0] {
      D_IDLE = 5'h01,
      D_RX   = 5'h02,
      D_ACK  = 5'h04,
      D_TX   = 5'h08,
      D_RACK = 5'h10
   } eegrd_dst_type;

   function automatic logic addr_ok(input logic [7:0] b);
      addr_ok = b[7:4] == DEV_CODE && b[3] == SLAVE_SEL_A
             && b[2] == SLAVE_SEL_B;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Link domain: synchronise and filter.

   logic [1:0]    sy1_r, sy2_r, flt_r, prv_r;
   logic [2:0]    fcnt_r [2];
   logic          wp1_r, wp2_r, ak1_r, ak2_r;
   logic          req_t_r, ack_t_r;
   logic [7:0]    mem_r [MEM_DEPTH];
   eegrd_dst_type st_r;
   logic [3:0]    bit_r;
   logic [1:0]    byte_r;
   logic [7:0]    sh_r;
   logic          rw_r, oe_r, wp_hit_r;
   logic [8:0]    ptr_r;
   logic [7:0]    wbuf_r [16];
   logic [15:0]   wval_r;

   always_ff @(posedge link_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sy1_r <= 2'h3;
         sy2_r <= 2'h3;
         prv_r <= 2'h3;
         wp1_r <= 1'b0;
         wp2_r <= 1'b0;
         ak1_r <= 1'b0;
         ak2_r <= 1'b0;
      end else begin
         sy1_r <= {bus.sda, bus.scl};
         sy2_r <= sy1_r;
         prv_r <= flt_r;
         wp1_r <= bus.wp;
         wp2_r <= wp1_r;
         ak1_r <= ack_t_r;
         ak2_r <= ak1_r;
      end
   end

   // A new level must hold for FILT_CYC samples before it counts.
   for (genvar g = 0; g < 2; g++) begin : g_filt
      always_ff @(posedge link_clk_in or negedge nrst_in) begin
         if (!nrst_in) begin
            fcnt_r[g] <= 3'h0;
            flt_r[g]  <= 1'b1;
         end else if (sy2_r[g] == flt_r[g]) begin
            fcnt_r[g] <= 3'h0;
         end else if (fcnt_r[g] == FILT_CYC - 3'h1) begin
            fcnt_r[g] <= 3'h0;
            flt_r[g]  <= sy2_r[g];
         end else begin
            fcnt_r[g] <= fcnt_r[g] + 3'h1;
         end
      end
   end

   logic start_w, stop_w, rise_w, fall_w, pend_w, rxdone_w, txend_w;
   logic [7:0] mem_q_w;

   assign start_w  = flt_r[0] & prv_r[0] & prv_r[1] & ~flt_r[1];
   assign stop_w   = flt_r[0] & prv_r[0] & ~prv_r[1] & flt_r[1];
   assign rise_w   = flt_r[0] & ~prv_r[0];
   assign fall_w   = ~flt_r[0] & prv_r[0];
   // Write pending until the system side hands back the toggle.
   assign pend_w   = req_t_r ^ ak2_r;
   assign rxdone_w = !pend_w && st_r == D_RX && fall_w
                  && bit_r == BIT_LAST;
   assign txend_w  = !pend_w && st_r == D_TX && fall_w
                  && bit_r == BIT_LAST - 4'h1;
   // The array only changes while pend_w holds reads off.
   assign mem_q_w  = mem_r[ptr_r];

   ////////////////////////////////////////////////////////////////////
   // Link domain: bit sequencer.

   always_ff @(posedge link_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r   <= D_IDLE;
         bit_r  <= 4'h0;
         byte_r <= 2'h0;
         sh_r   <= 8'h00;
         rw_r   <= 1'b0;
         oe_r   <= 1'b0;
      end else if (pend_w) begin
         st_r <= D_IDLE;
         oe_r <= 1'b0;
      end else if (start_w) begin
         st_r   <= D_RX;
         bit_r  <= 4'h0;
         byte_r <= 2'h0;
         oe_r   <= 1'b0;
      end else if (stop_w) begin
         st_r <= D_IDLE;
         oe_r <= 1'b0;
      end else begin
         unique case (st_r)
            D_IDLE: ;
            D_RX: begin
               if (rise_w) begin
                  sh_r  <= {sh_r[6:0], flt_r[1]};
                  bit_r <= bit_r + 4'h1;
               end else if (rxdone_w) begin
                  if (byte_r != 2'h0 || addr_ok(sh_r)) begin
                     st_r <= D_ACK;
                     oe_r <= 1'b1;
                  end else begin
                     st_r <= D_IDLE;
                  end
                  if (byte_r == 2'h0)
                     rw_r <= sh_r[0];
               end
            end
            D_ACK: begin
               if (fall_w) begin
                  bit_r <= 4'h0;
                  if (rw_r) begin
                     st_r <= D_TX;
                     sh_r <= mem_q_w;
                     oe_r <= ~mem_q_w[7];
                  end else begin
                     st_r   <= D_RX;
                     oe_r   <= 1'b0;
                     byte_r <= (byte_r == 2'h2) ? 2'h2 : byte_r + 2'h1;
                  end
               end
            end
            // Drives eight bits, then releases the line for the host's acknowledge.
            D_TX: begin
               if (txend_w) begin
                  st_r <= D_RACK;
                  oe_r <= 1'b0;
               end else if (fall_w) begin
                  sh_r  <= {sh_r[6:0], 1'b1};
                  oe_r  <= ~sh_r[6];
                  bit_r <= bit_r + 4'h1;
               end
            end
            D_RACK: begin
               if (rise_w && flt_r[1]) begin
                  st_r <= D_IDLE;
               end else if (fall_w) begin
                  st_r  <= D_TX;
                  bit_r <= 4'h0;
                  sh_r  <= mem_q_w;
                  oe_r  <= ~mem_q_w[7];
               end
            end
            default: st_r <= D_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Link domain: pointer, page buffer and write request.

   always_ff @(posedge link_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ptr_r    <= 9'h000;
         wval_r   <= 16'h0000;
         wp_hit_r <= 1'b0;
         req_t_r  <= 1'b0;
      end else if (!pend_w) begin
         if (start_w) begin
            wval_r   <= 16'h0000;
            wp_hit_r <= wp2_r;
         end else if (stop_w) begin
            // The buffer must stand until the write cycle has copied it.
            if (!rw_r && |wval_r && !wp_hit_r)
               req_t_r <= ~req_t_r;
            else
               wval_r <= 16'h0000;
         end else begin
            if (st_r != D_IDLE && wp2_r)
               wp_hit_r <= 1'b1;
            if (rxdone_w && byte_r == 2'h0 && addr_ok(sh_r))
               ptr_r[8] <= sh_r[1];
            if (rxdone_w && !rw_r && byte_r == 2'h1)
               ptr_r[7:0] <= sh_r;
            if (rxdone_w && !rw_r && byte_r == 2'h2) begin
               wbuf_r[ptr_r[3:0]] <= sh_r;
               wval_r[ptr_r[3:0]] <= 1'b1;
               ptr_r[3:0]         <= ptr_r[3:0] + 4'h1;
            end
            if (txend_w)
               ptr_r <= ptr_r + 9'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // System domain: power-on hold, supply guard, write cycle.

   logic        rq1_r, rq2_r, rq3_r, lv1_r, lv2_r;
   logic        busy_r, por_done_r;
   logic [7:0]  por_cnt_r;
   logic [23:0] tmr_r;

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rq1_r       <= 1'b0;
         rq2_r       <= 1'b0;
         rq3_r       <= 1'b0;
         lv1_r       <= 1'b1;
         lv2_r       <= 1'b1;
         por_cnt_r   <= 8'h00;
         por_done_r  <= 1'b0;
      end else begin
         rq1_r <= req_t_r;
         rq2_r <= rq1_r;
         rq3_r <= rq2_r;
         lv1_r <= supply_low_in;
         lv2_r <= lv1_r;
         if (por_cnt_r == POR_CYC)
            por_done_r <= 1'b1;
         else
            por_cnt_r <= por_cnt_r + 8'h01;
      end
   end

   // A refused request is answered at once so the link never hangs.
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         busy_r  <= 1'b0;
         ack_t_r <= 1'b0;
         tmr_r   <= 24'h00_0000;
      end else if (busy_r) begin
         tmr_r <= tmr_r + 24'h00_0001;
         if (tmr_r == 24'(WR_CYC - 1)) begin
            busy_r  <= 1'b0;
            ack_t_r <= ~ack_t_r;
         end
      end else if (rq3_r ^ rq2_r) begin
         tmr_r <= 24'h00_0000;
         if (por_done_r && !lv2_r)
            busy_r <= 1'b1;
         else
            ack_t_r <= ~ack_t_r;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (busy_r && tmr_r[23:4] == 20'h0_0000 && wval_r[tmr_r[3:0]])
         mem_r[{ptr_r[8:4], tmr_r[3:0]}] <= wbuf_r[tmr_r[3:0]];
   end

   assign busy_out      = busy_r;
   assign bus.sda_d_oe  = oe_r;
   assign bus.sda_d_out = 1'b0;

endmodule // eegrd_dev

// ===== core/eegrd_host.sv
/*
 * Host end: drives the bus clock from a divider, runs byte write,
 * current-address read and software reset, and recovers the bus
 * after reset.
 * Assumes the device end and pull-up are joined through eegrd_if.
 */
`timescale 1ns/10ps
module eegrd_host
   import eegrd_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       nrst_in,
   // Two-wire bus
   eegrd_if.host           bus,
   // Command port
   input  wire logic       cmd_valid_in,
   input  wire logic [1:0] cmd_kind_in,
   input  wire logic [8:0] cmd_addr_in,
   input  wire logic [7:0] cmd_data_in,
   input  wire logic       protect_in,
   // Answer port
   output logic            ready_out,
   output logic            done_out,
   output logic [7:0]      rdata_out,
   output logic            nack_out
);

   typedef enum logic [4:0] {
      H_INIT  = 5'h01,
      H_IDLE  = 5'h02,
      H_START = 5'h04,
      H_BIT   = 5'h08,
      H_STOP  = 5'h10
   } eegrd_hst_type;

   function automatic logic [8:0] slot_bits(input logic [1:0] kind,
      input logic [1:0] idx, input logic [8:0] addr,
      input logic [7:0] data);
      logic [8:0] hdr;
      hdr = {DEV_CODE, SLAVE_SEL_A, SLAVE_SEL_B, addr[8],
             kind == CMD_READ, 1'b1};
      if (kind == CMD_SRST || (kind == CMD_READ && idx != 2'h0))
         slot_bits = 9'h1ff;
      else if (idx == 2'h0)
         slot_bits = hdr;
      else if (idx == 2'h1)
         slot_bits = {addr[7:0], 1'b1};
      else
         slot_bits = {data, 1'b1};
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Quarter-period divider and data input synchroniser.

   logic [7:0] qcnt_r;
   logic [1:0] q_r;
   logic       tick_w, sd1_r, sd2_r;

   assign tick_w = qcnt_r == QTR_CYC - 8'h01;

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         qcnt_r <= 8'h00;
         q_r    <= 2'h0;
         sd1_r  <= 1'b1;
         sd2_r  <= 1'b1;
      end else begin
         qcnt_r <= tick_w ? 8'h00 : qcnt_r + 8'h01;
         if (tick_w)
            q_r <= q_r + 2'h1;
         sd1_r <= bus.sda;
         sd2_r <= sd1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Transfer sequencer.

   eegrd_hst_type st_r;
   logic [1:0]    kind_r, slot_r, last_w;
   logic [8:0]    addr_r, tx_r, rx_r;
   logic [7:0]    data_r;
   logic [3:0]    bitn_r;
   logic          scl_r, sdo_r, sdoe_r, wp_r, restart_r, chk_w;

   assign last_w = (kind_r == CMD_WRITE) ? 2'h2
                 : (kind_r == CMD_READ) ? 2'h1 : 2'h0;
   assign chk_w  = kind_r != CMD_SRST
                && !(kind_r == CMD_READ && slot_r != 2'h0);

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r      <= H_INIT;
         kind_r    <= CMD_SRST;
         addr_r    <= 9'h000;
         data_r    <= 8'h00;
         slot_r    <= 2'h0;
         bitn_r    <= 4'h0;
         tx_r      <= 9'h1ff;
         rx_r      <= 9'h000;
         scl_r     <= 1'b1;
         sdo_r     <= 1'b1;
         sdoe_r    <= 1'b1;
         wp_r      <= 1'b0;
         restart_r <= 1'b0;
         ready_out <= 1'b0;
         done_out  <= 1'b0;
         rdata_out <= 8'h00;
         nack_out  <= 1'b0;
      end else begin
         done_out <= 1'b0;
         unique case (st_r)
            // Lines held high, then a software reset.
            H_INIT: begin
               if (tick_w && q_r == 2'h3)
                  st_r <= H_START;
            end
            H_IDLE: begin
               scl_r  <= 1'b1;
               sdo_r  <= 1'b1;
               sdoe_r <= 1'b1;
               if (cmd_valid_in && tick_w && q_r == 2'h3) begin
                  kind_r    <= cmd_kind_in;
                  addr_r    <= cmd_addr_in;
                  data_r    <= cmd_data_in;
                  wp_r      <= protect_in;
                  ready_out <= 1'b0;
                  nack_out  <= 1'b0;
                  restart_r <= 1'b0;
                  slot_r    <= 2'h0;
                  st_r      <= H_START;
               end
            end
            H_START: if (tick_w) begin
               unique case (q_r)
                  2'h0: begin
                     scl_r  <= 1'b0;
                     sdoe_r <= 1'b0;
                  end
                  2'h1: scl_r <= 1'b1;
                  2'h2: begin
                     sdo_r  <= 1'b0;
                     sdoe_r <= 1'b1;
                  end
                  2'h3: begin
                     scl_r  <= 1'b0;
                     bitn_r <= 4'h0;
                     tx_r   <= slot_bits(kind_r, 2'h0, addr_r, data_r);
                     st_r   <= restart_r ? H_STOP : H_BIT;
                  end
               endcase
            end
            H_BIT: if (tick_w) begin
               unique case (q_r)
                  2'h0: begin
                     sdo_r  <= tx_r[8];
                     sdoe_r <= ~tx_r[8];
                  end
                  2'h1: scl_r <= 1'b1;
                  2'h2: rx_r <= {rx_r[7:0], sd2_r};
                  2'h3: begin
                     scl_r  <= 1'b0;
                     tx_r   <= {tx_r[7:0], 1'b1};
                     bitn_r <= bitn_r + 4'h1;
                     if (bitn_r == BIT_LAST) begin
                        bitn_r <= 4'h0;
                        if (chk_w && rx_r[0]) begin
                           nack_out <= 1'b1;
                           st_r     <= H_STOP;
                        end else if (slot_r == last_w) begin
                           if (kind_r == CMD_READ)
                              rdata_out <= rx_r[8:1];
                           if (kind_r == CMD_SRST && !restart_r) begin
                              restart_r <= 1'b1;
                              st_r      <= H_START;
                           end else begin
                              st_r <= H_STOP;
                           end
                        end else begin
                           slot_r <= slot_r + 2'h1;
                           tx_r   <= slot_bits(kind_r, slot_r + 2'h1,
                                               addr_r, data_r);
                        end
                     end
                  end
               endcase
            end
            H_STOP: if (tick_w) begin
               unique case (q_r)
                  2'h0: begin
                     scl_r  <= 1'b0;
                     sdo_r  <= 1'b0;
                     sdoe_r <= 1'b1;
                  end
                  2'h1: scl_r <= 1'b1;
                  2'h2: sdo_r <= 1'b1;
                  2'h3: begin
                     wp_r      <= 1'b0;
                     done_out  <= 1'b1;
                     ready_out <= 1'b1;
                     st_r      <= H_IDLE;
                  end
               endcase
            end
            default: st_r <= H_IDLE;
         endcase
      end
   end

   assign bus.scl       = scl_r;
   assign bus.sda_m_out = sdo_r;
   assign bus.sda_m_oe  = sdoe_r;
   assign bus.wp        = wp_r;

endmodule // eegrd_host

// ===== test/eegrd_monitor.sv
/*
 * Checker of the EEPROM guard bus lines and write-cycle status.
 * Assumes its inputs come from the interface and the device end.
 */
`timescale 1ns/10ps
module eegrd_monitor #(
   parameter int WR_CYC = 200
) (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   // Bus lines
   input wire logic scl,
   input wire logic sda_m_out,
   input wire logic sda_m_oe,
   input wire logic sda_d_out,
   input wire logic sda_d_oe,
   input wire logic wp,
   input wire logic sda,
   // Device status
   input wire logic busy_out,
   input wire logic supply_low_in
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   ////////////////////////////////////////////////////////////////////////
   // A counter stands in for a long repetition, which tools unroll badly.
   int busy_cnt_r;
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         busy_cnt_r <= 0;
      end else begin
         busy_cnt_r <= busy_out ? busy_cnt_r + 1 : 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   property p_no_ack_busy;
      busy_out |-> !sda_d_oe;
   endproperty
   a_no_ack_busy: assert property (p_no_ack_busy)
      else $error("Device drove the data line in a write cycle.");
   property p_host_releases;
      sda_d_oe |-> !(sda_m_oe && sda_m_out);
   endproperty
   a_host_releases: assert property (p_host_releases)
      else $error("Host drove high against the device.");
   property p_dev_pulls_low;
      sda_d_oe |-> !sda_d_out && !sda;
   endproperty
   a_dev_pulls_low: assert property (p_dev_pulls_low)
      else $error("Device drive did not pull the line low.");
   property p_dev_lets_go;
      $rose(sda_d_oe) |-> ##[1:600] !sda_d_oe;
   endproperty
   a_dev_lets_go: assert property (p_dev_lets_go)
      else $error("Device held the data line too long.");
   property p_wp_blocks;
      $rose(busy_out) |-> !wp;
   endproperty
   a_wp_blocks: assert property (p_wp_blocks)
      else $error("Write cycle began while writes were inhibited.");
   property p_supply_blocks;
      $rose(busy_out) |-> !supply_low_in;
   endproperty
   a_supply_blocks: assert property (p_supply_blocks)
      else $error("Write cycle began on a low supply.");
   property p_busy_len;
      $fell(busy_out) |-> busy_cnt_r == WR_CYC;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("Write cycle length was wrong.");
   property p_wp_held;
      $fell(wp) |-> scl && sda;
   endproperty
   a_wp_held: assert property (p_wp_held)
      else $error("Write inhibit dropped inside a transaction.");
endmodule // eegrd_monitor

// ===== test/eegrd_tb_top.sv
/*
 * Testbench joining host and device ends of the EEPROM guard.
 * Assumes the package, interface and both design ends are compiled.
 */
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module eegrd_tb_top;
   import eegrd_pkg::*;
   localparam int WR_CYC = 12000;
   logic       clk_sys, link_clk, nrst, supply_low, busy;
   logic       cmd_valid, protect, ready, done, nack;
   logic [1:0] cmd_kind;
   logic [8:0] cmd_addr;
   logic [7:0] cmd_data, rdata, abyte;
   int         compares = 0, miscompares = 0, rises = 0, gap = 0;
   eegrd_if bus();
   eegrd_dev #(.WR_CYC(WR_CYC)) eegrd_dev_i (.clk_sys_in(clk_sys),
      .link_clk_in(link_clk), .nrst_in(nrst), .bus(bus),
      .supply_low_in(supply_low), .busy_out(busy));
   eegrd_host eegrd_host_i (.clk_sys_in(clk_sys), .nrst_in(nrst),
      .bus(bus), .cmd_valid_in(cmd_valid), .cmd_kind_in(cmd_kind),
      .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data),
      .protect_in(protect), .ready_out(ready), .done_out(done),
      .rdata_out(rdata), .nack_out(nack));
   eegrd_monitor #(.WR_CYC(WR_CYC)) eegrd_monitor_i (.clk_sys_in(clk_sys),
      .nrst_in(nrst), .scl(bus.scl), .sda_m_out(bus.sda_m_out),
      .sda_m_oe(bus.sda_m_oe), .sda_d_out(bus.sda_d_out),
      .sda_d_oe(bus.sda_d_oe), .wp(bus.wp), .sda(bus.sda),
      .busy_out(busy), .supply_low_in(supply_low));
   ////////////////////////////////////////////////////////////////////////
   // Clocks are offset in phase and differ in period, so crossings see four repeating alignments.
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #15 link_clk = ~link_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   // Wire watch: first byte after a start and clock rises between starts.
   always @(posedge bus.scl) begin
      if (rises < 8) begin
         abyte = {abyte[6:0], bus.sda};
      end
      rises++;
   end
   always @(negedge bus.sda) begin
      if (bus.scl === 1'b1) begin
         gap = rises;
         rises = 0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1) begin
         @(negedge clk_sys);
         n++;
         if (n > 20000) begin
            miscompares++;
            test_done();
         end
      end
   endtask
   task automatic wait_busy(input logic val);
      int n;
      n = 0;
      while (busy !== val) begin
         @(negedge clk_sys);
         n++;
         if (n > 30000) begin
            miscompares++;
            test_done();
         end
      end
   endtask
   // The request stands until the host takes it, as its port expects.
   task automatic run(input logic [1:0] kind, input logic [8:0] addr,
                      input logic [7:0] data, input logic prot);
      int n;
      n = 0;
      cmd_kind = kind;
      cmd_addr = addr;
      cmd_data = data;
      protect = prot;
      cmd_valid = 1'b1;
      while (ready !== 1'b0) begin
         @(negedge clk_sys);
         n++;
         if (n > 2000) begin
            miscompares++;
            test_done();
         end
      end
      cmd_valid = 1'b0;
      wait_done();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      nrst = 1'b0;
      supply_low = 1'b0;
      cmd_valid = 1'b0;
      cmd_kind = CMD_WRITE;
      cmd_addr = 9'h000;
      cmd_data = 8'h00;
      protect = 1'b0;
      repeat (4) @(negedge clk_sys);
      nrst = 1'b1;
      wait_done();
      @(negedge clk_sys);
      `CHK(gap, 10);
      `CHK({ready, bus.scl, bus.sda}, 3'h7);
      $display("test power_up done");
      run(CMD_WRITE, 9'h1a5, 8'h5a, 1'b0);
      `CHK(nack, 1'b0);
      `CHK(abyte, {DEV_CODE, SLAVE_SEL_A, SLAVE_SEL_B, 2'h2});
      wait_busy(1'b1);
      run(CMD_WRITE, 9'h010, 8'h11, 1'b0);
      `CHK(nack, 1'b1);
      run(CMD_SRST, 9'h000, 8'h00, 1'b0);
      `CHK(busy, 1'b1);
      `CHK(gap, 10);
      wait_busy(1'b0);
      // A write leaves the pointer one past its cell, so a protected
      // write to the cell below aims the next read at the cell.
      run(CMD_WRITE, 9'h1a4, 8'ha5, 1'b1);
      `CHK(busy, 1'b0);
      run(CMD_READ, 9'h100, 8'h00, 1'b0);
      `CHK({nack, rdata}, 9'h05a);
      $display("test write_and_reset done");
      run(CMD_WRITE, 9'h1a5, 8'ha5, 1'b1);
      repeat (100) @(negedge clk_sys);
      `CHK(busy, 1'b0);
      run(CMD_WRITE, 9'h1a4, 8'ha5, 1'b1);
      run(CMD_READ, 9'h100, 8'h00, 1'b0);
      `CHK(rdata, 8'h5a);
      $display("test protect done");
      supply_low = 1'b1;
      run(CMD_WRITE, 9'h1a5, 8'h3c, 1'b0);
      repeat (100) @(negedge clk_sys);
      `CHK(busy, 1'b0);
      supply_low = 1'b0;
      run(CMD_WRITE, 9'h1a4, 8'ha5, 1'b1);
      run(CMD_READ, 9'h100, 8'h00, 1'b0);
      `CHK(rdata, 8'h5a);
      $display("test low_supply done");
      test_done();
   end
endmodule // eegrd_tb_top
